// ==== rtl/status_regs.svh ====
// Status register field positions, reserved bit masks and reset values
`ifndef STATUS_REGS_SVH
`define STATUS_REGS_SVH

// ----------------------------------------
// First status register layout
// ----------------------------------------
`define SR0_PTR_HI        15
`define SR0_PTR_LO        13
`define SR0_OVF_BIT       12
`define SR0_SAT_BIT       11
`define SR0_RSV_BIT       10
`define SR0_MASK_BIT      9
`define SR0_PAGE_HI       8
`define SR0_PAGE_LO       0

// ----------------------------------------
// Second status register layout
// ----------------------------------------
`define SR1_BUF_HI        15
`define SR1_BUF_LO        13
`define SR1_RAM_BIT       12
`define SR1_TEST_BIT      11
`define SR1_SIGN_BIT      10
`define SR1_CARRY_BIT     9
`define SR1_XOUT_BIT      4
`define SR1_SHIFT_HI      1
`define SR1_SHIFT_LO      0

// ----------------------------------------
// Reserved bits, all read as one
// ----------------------------------------
`define SR0_RSV_MASK      16'h0400
`define SR1_RSV_MASK      16'h01ec

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_PTR           3'h0
`define RST_PAGE          9'h000
`define RST_OVF           1'h0
`define RST_SAT           1'h0
`define RST_MASK          1'h1
`define RST_RAM           1'h0
`define RST_TEST          1'h0
`define RST_SIGN          1'h1
`define RST_CARRY         1'h1
`define RST_XOUT          1'h1
`define RST_SHIFT         2'h0

`endif

// ==== rtl/status_pkg.sv ====
// Types shared by the status register logic
package status_pkg;

  // ----------------------------------------
  // Selectable control bits for set/clear
  // ----------------------------------------
  typedef enum logic [2:0] {
    sel_carry,
    sel_ram,
    sel_mask,
    sel_sat,
    sel_sign,
    sel_test,
    sel_xout
  } bit_sel_type;

  // ----------------------------------------
  // Pointer load sources
  // ----------------------------------------
  typedef enum logic [1:0] {
    ptr_none,
    ptr_indirect,
    ptr_load,
    ptr_modify
  } ptr_src_type;

  // ----------------------------------------
  // Carry update kinds from the ALU
  // ----------------------------------------
  typedef enum logic [2:0] {
    cy_none,
    cy_add,
    cy_sub,
    cy_add_hi,
    cy_sub_hi,
    cy_shift
  } carry_op_type;

endpackage : status_pkg

// ==== rtl/product_scaler.sv ====
// Product shift path from the product holding register to the ALU
`timescale 1ns/10ps
`include "status_regs.svh"

module product_scaler
  import status_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        clk_en,
  input  wire logic [1:0]  product_shift_mode,
  input  wire logic [31:0] product_holding_reg,
  output logic      [31:0] scaled_product
);

  logic [31:0] scaled_nxt;

  // ----------------------------------------
  // Shift selection
  // ----------------------------------------
  // Holding register is only read, never rewritten
  always_comb
  begin
    case (product_shift_mode) // see RQ14
      2'h0:    scaled_nxt = product_holding_reg;
      2'h1:    scaled_nxt = {product_holding_reg[30:0], 1'h0};
      2'h2:    scaled_nxt = {product_holding_reg[27:0], 4'h0};
      2'h3:    scaled_nxt = {{6{product_holding_reg[31]}},
                             product_holding_reg[31:6]};
      default: scaled_nxt = product_holding_reg;
    endcase
  end

  // ----------------------------------------
  // Registered output
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      scaled_product <= 32'h0000_0000;
    else if (clk_en)
      scaled_product <= scaled_nxt; // see RQ15
  end

endmodule : product_scaler

// ==== rtl/cpu_status_flag_registers.sv ====
// Core status registers, their field update logic and mode outputs
`timescale 1ns/10ps
`include "status_regs.svh"

// Operation
// RQ1: New pointer, except via load-status, pushes old pointer into buffer.
// RQ2: Load-status writing buffer also copies that value into pointer.
// RQ3: Pointer selects indirect register; changed by indirect, load, modify, status.
// RQ4: Add carry sets carry; subtract borrow clears it; else opposite.
// RQ5: Shifted-by-16 add may only set, subtract may only clear carry.
// RQ6: Carry is one at reset; shifts, set/clear, load-status update it.
// RQ7: RAM select zero maps blocks to data space; reset clears it.
// RQ8: Direct address is page pointer joined with instruction's seven bits.
// RQ9: Global mask one blocks maskable interrupts; never reset or nonmaskable.
// RQ10: Mask set by reset and trap; set/clear change it; status never.
// RQ11: Overflow flag latches until reset, overflow branch, or load-status.
// RQ12: Saturate enable one clamps accumulator; zero lets it wrap.
// RQ13: Saturate enable changed by set/clear and load-status.
// RQ14: Product shift mode picks none, left one, left four, right six.
// RQ15: Shift applies only on transfer; set by mode instr, status; reset clears.
// RQ16: Sign extend mode one extends shifter data; some instructions ignore it.
// RQ17: Sign extend mode one at reset; set/clear and load-status change it.
// RQ18: Test flag set by bit test, aux compare, or normalize exclusive-or.
// RQ19: Output pin follows output flag; set/clear change it; one at reset.
// RQ20: Reserved bits of both status registers read as one.
// RQ21: First register holds pointer, overflow, saturate, mask, page pointer.
// RQ22: Second register holds buffer, RAM select, test, sign, carry, out, mode.
module cpu_status_flag_registers
  import status_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        clk_en,
  input  wire logic        ptr_load,
  input  wire ptr_src_type ptr_src,
  input  wire logic [2:0]  ptr_value,
  input  wire logic        load_status_instr,
  input  wire logic        status_sel_one,
  input  wire logic [15:0] status_wdata,
  input  wire logic        set_control_bit_instr,
  input  wire logic        clear_control_bit_instr,
  input  wire bit_sel_type control_bit_sel,
  input  wire logic        load_page_instr,
  input  wire logic [8:0]  page_value,
  input  wire logic        set_product_mode_instr,
  input  wire logic [1:0]  mode_value,
  input  wire carry_op_type carry_op,
  input  wire logic        alu_carry_out,
  input  wire logic        shift_carry_in,
  input  wire logic        alu_overflow,
  input  wire logic        overflow_branch,
  input  wire logic        trap_taken,
  input  wire logic        test_update,
  input  wire logic        tested_bit,
  input  wire logic        aux_compare_true,
  input  wire logic [1:0]  acc_top_bits,
  input  wire logic        leading_sign_instr_test,
  input  wire logic [6:0]  instr_low_bits,
  input  wire logic        maskable_irq_req,
  input  wire logic        nonmask_irq_req,
  input  wire logic        add_plain_instr,
  input  wire logic [31:0] product_holding_reg,
  output logic [15:0]      cpu_status_zero,
  output logic [15:0]      cpu_status_one,
  output logic [2:0]       aux_register_pointer,
  output logic [15:0]      direct_address,
  output logic             irq_accept,
  output logic             general_output_flag,
  output logic             ram_block_select,
  output logic             saturate_enable,
  output logic             sign_extend_eff,
  output logic [31:0]      scaled_product
);

  // ----------------------------------------
  // Field registers
  // ----------------------------------------
  logic [2:0] ptr_r;
  logic [2:0] buf_r;
  logic       ovf_r;
  logic       sat_r;
  logic       mask_r;
  logic [8:0] page_r;
  logic       ram_r;
  logic       test_r;
  logic       sign_r;
  logic       carry_r;
  logic       xout_r;
  logic [1:0] shift_r;

  logic       load_s0;
  logic       load_s1;

  assign load_s0 = load_status_instr && !status_sel_one;
  assign load_s1 = load_status_instr && status_sel_one;

  // Set/clear decode shared by all control bits
  function automatic logic bit_hit(input logic op,
                                   input bit_sel_type sel,
                                   input bit_sel_type want);
    bit_hit = op && (sel == want);
  endfunction : bit_hit

  // ----------------------------------------
  // Pointer and buffer
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ptr_r <= `RST_PTR;
      buf_r <= `RST_PTR;
    end
    else if (clk_en)
    begin
      if (load_s1)
      begin
        buf_r <= status_wdata[`SR1_BUF_HI:`SR1_BUF_LO];
        ptr_r <= status_wdata[`SR1_BUF_HI:`SR1_BUF_LO]; // see RQ2
      end
      else if (load_s0)
        ptr_r <= status_wdata[`SR0_PTR_HI:`SR0_PTR_LO]; // see RQ1
      else if (ptr_load && ptr_src != ptr_none)
      begin
        buf_r <= ptr_r; // see RQ1
        ptr_r <= ptr_value; // see RQ3
      end
    end
  end

  // ----------------------------------------
  // Carry
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      carry_r <= `RST_CARRY; // see RQ6
    else if (clk_en)
    begin
      if (load_s1)
        carry_r <= status_wdata[`SR1_CARRY_BIT];
      else if (bit_hit(set_control_bit_instr, control_bit_sel, sel_carry))
        carry_r <= 1'h1;
      else if (bit_hit(clear_control_bit_instr, control_bit_sel, sel_carry))
        carry_r <= 1'h0;
      else
        case (carry_op)
          cy_add:    carry_r <= alu_carry_out; // see RQ4
          cy_sub:    carry_r <= alu_carry_out; // see RQ4
          cy_add_hi: carry_r <= carry_r | alu_carry_out; // see RQ5
          cy_sub_hi: carry_r <= carry_r & alu_carry_out; // see RQ5
          cy_shift:  carry_r <= shift_carry_in; // see RQ6
          default:   carry_r <= carry_r;
        endcase
    end
  end

  // ----------------------------------------
  // Overflow flag and saturate mode
  // ----------------------------------------
  // Overflow event wins over a same-cycle clear
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      ovf_r <= `RST_OVF;
    else if (clk_en)
    begin
      if (alu_overflow)
        ovf_r <= 1'h1; // see RQ11
      else if (overflow_branch || load_s0)
        ovf_r <= load_s0 ? status_wdata[`SR0_OVF_BIT] : 1'h0; // see RQ11
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      sat_r <= `RST_SAT;
    else if (clk_en)
    begin
      if (load_s0)
        sat_r <= status_wdata[`SR0_SAT_BIT]; // see RQ13
      else if (bit_hit(set_control_bit_instr, control_bit_sel, sel_sat))
        sat_r <= 1'h1; // see RQ13
      else if (bit_hit(clear_control_bit_instr, control_bit_sel, sel_sat))
        sat_r <= 1'h0; // see RQ13
    end
  end

  // ----------------------------------------
  // Global interrupt mask
  // ----------------------------------------
  // Load-status leaves it alone so a restore cannot reopen interrupts
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      mask_r <= `RST_MASK; // see RQ10
    else if (clk_en)
    begin
      if (trap_taken)
        mask_r <= 1'h1; // see RQ10
      else if (bit_hit(set_control_bit_instr, control_bit_sel, sel_mask))
        mask_r <= 1'h1; // see RQ10
      else if (bit_hit(clear_control_bit_instr, control_bit_sel, sel_mask))
        mask_r <= 1'h0; // see RQ10
    end
  end

  // ----------------------------------------
  // Data page pointer
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      page_r <= `RST_PAGE;
    else if (clk_en)
    begin
      if (load_s0)
        page_r <= status_wdata[`SR0_PAGE_HI:`SR0_PAGE_LO]; // see RQ8
      else if (load_page_instr)
        page_r <= page_value; // see RQ8
    end
  end

  // ----------------------------------------
  // RAM select, sign extend, output flag
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ram_r  <= `RST_RAM; // see RQ7
      sign_r <= `RST_SIGN; // see RQ17
      xout_r <= `RST_XOUT; // see RQ19
    end
    else if (clk_en)
    begin
      if (load_s1)
      begin
        ram_r  <= status_wdata[`SR1_RAM_BIT]; // see RQ7
        sign_r <= status_wdata[`SR1_SIGN_BIT]; // see RQ17
      end
      else
      begin
        if (bit_hit(set_control_bit_instr, control_bit_sel, sel_ram))
          ram_r <= 1'h1; // see RQ7
        else if (bit_hit(clear_control_bit_instr, control_bit_sel, sel_ram))
          ram_r <= 1'h0; // see RQ7
        if (bit_hit(set_control_bit_instr, control_bit_sel, sel_sign))
          sign_r <= 1'h1; // see RQ17
        else if (bit_hit(clear_control_bit_instr, control_bit_sel, sel_sign))
          sign_r <= 1'h0; // see RQ17
      end
      if (bit_hit(set_control_bit_instr, control_bit_sel, sel_xout))
        xout_r <= 1'h1; // see RQ19
      else if (bit_hit(clear_control_bit_instr, control_bit_sel, sel_xout))
        xout_r <= 1'h0; // see RQ19
    end
  end

  // ----------------------------------------
  // Test/control flag
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      test_r <= `RST_TEST;
    else if (clk_en)
    begin
      if (load_s1)
        test_r <= status_wdata[`SR1_TEST_BIT];
      else if (bit_hit(set_control_bit_instr, control_bit_sel, sel_test))
        test_r <= 1'h1;
      else if (bit_hit(clear_control_bit_instr, control_bit_sel, sel_test))
        test_r <= 1'h0;
      else if (leading_sign_instr_test)
        test_r <= acc_top_bits[1] ^ acc_top_bits[0]; // see RQ18
      else if (test_update)
        test_r <= tested_bit | aux_compare_true; // see RQ18
    end
  end

  // ----------------------------------------
  // Product shift mode
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      shift_r <= `RST_SHIFT; // see RQ15
    else if (clk_en)
    begin
      if (load_s1)
        shift_r <= status_wdata[`SR1_SHIFT_HI:`SR1_SHIFT_LO]; // see RQ15
      else if (set_product_mode_instr)
        shift_r <= mode_value; // see RQ15
    end
  end

  product_scaler u_scaler (
    .ref_clk             (ref_clk),
    .rst_n               (rst_n),
    .clk_en              (clk_en),
    .product_shift_mode  (shift_r),
    .product_holding_reg (product_holding_reg),
    .scaled_product      (scaled_product)
  );

  // ----------------------------------------
  // Read view and mode outputs
  // ----------------------------------------
  always_comb
  begin
    cpu_status_zero = `SR0_RSV_MASK; // see RQ20
    cpu_status_zero[`SR0_PTR_HI:`SR0_PTR_LO] = ptr_r; // see RQ21
    cpu_status_zero[`SR0_OVF_BIT]            = ovf_r;
    cpu_status_zero[`SR0_SAT_BIT]            = sat_r;
    cpu_status_zero[`SR0_MASK_BIT]           = mask_r;
    cpu_status_zero[`SR0_PAGE_HI:`SR0_PAGE_LO] = page_r;
  end

  always_comb
  begin
    cpu_status_one = `SR1_RSV_MASK; // see RQ20
    cpu_status_one[`SR1_BUF_HI:`SR1_BUF_LO]     = buf_r; // see RQ22
    cpu_status_one[`SR1_RAM_BIT]                = ram_r;
    cpu_status_one[`SR1_TEST_BIT]               = test_r;
    cpu_status_one[`SR1_SIGN_BIT]               = sign_r;
    cpu_status_one[`SR1_CARRY_BIT]              = carry_r;
    cpu_status_one[`SR1_XOUT_BIT]               = xout_r;
    cpu_status_one[`SR1_SHIFT_HI:`SR1_SHIFT_LO] = shift_r;
  end

  assign aux_register_pointer = ptr_r; // see RQ3
  assign direct_address       = {page_r, instr_low_bits}; // see RQ8
  // Nonmaskable requests bypass the mask entirely
  assign irq_accept           = nonmask_irq_req
                                | (maskable_irq_req & ~mask_r); // see RQ9
  assign general_output_flag  = xout_r; // see RQ19
  assign ram_block_select     = ram_r; // see RQ7
  assign saturate_enable      = sat_r; // see RQ12
  assign sign_extend_eff      = sign_r & ~add_plain_instr; // see RQ16

endmodule : cpu_status_flag_registers

// ==== verification/status_checker.sv ====
// Concurrent checks on the status register block ports
`timescale 1ns/10ps
module status_checker
  import status_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire logic        clk_en,
  input wire logic        load_status_instr,
  input wire logic        status_sel_one,
  input wire logic [15:0] status_wdata,
  input wire logic        load_page_instr,
  input wire logic        alu_overflow,
  input wire logic        overflow_branch,
  input wire logic [6:0]  instr_low_bits,
  input wire logic        maskable_irq_req,
  input wire logic        nonmask_irq_req,
  input wire logic        add_plain_instr,
  input wire logic [15:0] cpu_status_zero,
  input wire logic [15:0] cpu_status_one,
  input wire logic [15:0] direct_address,
  input wire logic        irq_accept,
  input wire logic        sign_extend_eff
);
  // ------------------------------
  // Clocking
  // ------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  // ------------------------------
  // Properties
  // ------------------------------
  reserved_ones_a: assert property (
    cpu_status_zero[10] && (cpu_status_one & 16'h01ec) == 16'h01ec)
    else $error("Reserved status bits not one");
  direct_addr_a: assert property (
    direct_address == {cpu_status_zero[8:0], instr_low_bits})
    else $error("Direct address not page and low bits");
  irq_gate_a: assert property (
    irq_accept == (nonmask_irq_req
                   | (maskable_irq_req & ~cpu_status_zero[9])))
    else $error("Interrupt gating wrong");
  sign_ext_a: assert property (
    sign_extend_eff == (cpu_status_one[10] & ~add_plain_instr))
    else $error("Effective sign extension wrong");
  pointer_copy_a: assert property (
    clk_en && load_status_instr && status_sel_one |=>
    cpu_status_zero[15:13] == $past(status_wdata[15:13])
    && cpu_status_one[15:13] == $past(status_wdata[15:13]))
    else $error("Buffer load did not reach pointer");
  page_hold_a: assert property (
    !clk_en || !(load_page_instr || load_status_instr) |=>
    $stable(cpu_status_zero[8:0]))
    else $error("Page pointer changed without load");
  ovf_latch_a: assert property (
    clk_en && alu_overflow |=> cpu_status_zero[12])
    else $error("Overflow flag not latched");
  ovf_hold_a: assert property (
    cpu_status_zero[12] && !overflow_branch
    && !(load_status_instr && !status_sel_one) |=> cpu_status_zero[12])
    else $error("Overflow flag dropped");
endmodule : status_checker

bind cpu_status_flag_registers status_checker i_status_checker
(
  .ref_clk, .rst_n, .clk_en, .load_status_instr, .status_sel_one,
  .status_wdata, .load_page_instr, .alu_overflow, .overflow_branch,
  .instr_low_bits, .maskable_irq_req, .nonmask_irq_req,
  .add_plain_instr, .cpu_status_zero, .cpu_status_one,
  .direct_address, .irq_accept, .sign_extend_eff
);

// ==== verification/testbench.sv ====
// Random instruction bench for the status register block
`timescale 1ns/10ps
module testbench
  import status_pkg::*;
;
  typedef struct {logic [1:0] k; logic [31:0] v;} note_type;
  logic ref_clk, rst_n, clk_en, ptr_load, load_status_instr, status_sel_one;
  logic set_control_bit_instr, clear_control_bit_instr, load_page_instr;
  logic set_product_mode_instr, alu_carry_out, shift_carry_in, alu_overflow;
  logic overflow_branch, trap_taken, test_update, tested_bit, aux_compare_true;
  logic leading_sign_instr_test, maskable_irq_req, nonmask_irq_req, add_plain_instr;
  logic irq_accept, general_output_flag, ram_block_select, saturate_enable;
  logic sign_extend_eff, e_ovf, e_sat, e_mask, e_ram;
  logic e_test, e_sign, e_cy, e_xo;
  logic [1:0]   mode_value, acc_top_bits, e_shift;
  logic [2:0]   ptr_value, aux_register_pointer, e_ptr, e_buf;
  logic [6:0]   instr_low_bits;
  logic [8:0]   page_value, e_page;
  logic [15:0]  status_wdata, cpu_status_zero, cpu_status_one, direct_address;
  logic [31:0]  product_holding_reg, scaled_product;
  ptr_src_type  ptr_src;
  bit_sel_type  control_bit_sel;
  carry_op_type carry_op;
  note_type     notes[$];
  note_type     cur;
  int           mismatches;
  int           samples_checked;

  cpu_status_flag_registers i_cpu_status_flag_registers
  (
    .ref_clk, .rst_n, .clk_en, .ptr_load, .ptr_src, .ptr_value,
    .load_status_instr, .status_sel_one, .status_wdata,
    .set_control_bit_instr, .clear_control_bit_instr, .control_bit_sel,
    .load_page_instr, .page_value, .set_product_mode_instr, .mode_value,
    .carry_op, .alu_carry_out, .shift_carry_in, .alu_overflow,
    .overflow_branch, .trap_taken, .test_update, .tested_bit,
    .aux_compare_true, .acc_top_bits, .leading_sign_instr_test, .instr_low_bits,
    .maskable_irq_req, .nonmask_irq_req, .add_plain_instr,
    .product_holding_reg, .cpu_status_zero, .cpu_status_one,
    .aux_register_pointer, .direct_address, .irq_accept,
    .general_output_flag, .ram_block_select, .saturate_enable,
    .sign_extend_eff, .scaled_product
  );

  // ------------------------------
  // Notes and result watcher
  // ------------------------------
  function automatic logic [31:0] seen(input logic [1:0] k);
    case (k)
      2'h0: return {16'h0, cpu_status_zero};
      2'h1: return {16'h0, cpu_status_one};
      2'h2: return {8'h0, direct_address, aux_register_pointer,
                    general_output_flag, ram_block_select,
                    saturate_enable, sign_extend_eff, irq_accept};
      default: return scaled_product;
    endcase
  endfunction : seen

  // Every output is noted after each step, so stray updates show up
  task automatic note_all();
    logic [31:0] sp;
    case (e_shift)
      2'h0: sp = product_holding_reg;
      2'h1: sp = product_holding_reg << 1;
      2'h2: sp = product_holding_reg << 4;
      default: sp = $signed(product_holding_reg) >>> 6;
    endcase
    notes.push_back('{2'h0, {16'h0, e_ptr, e_ovf, e_sat,
                             1'h1, e_mask, e_page}});
    notes.push_back('{2'h1, {16'h0, e_buf, e_ram, e_test, e_sign, e_cy, 4'hf,
                             e_xo, 2'h3, e_shift}});
    notes.push_back('{2'h2, {8'h0, e_page, instr_low_bits, e_ptr, e_xo, e_ram,
                             e_sat, e_sign & ~add_plain_instr,
                             nonmask_irq_req | (maskable_irq_req & ~e_mask)}});
    notes.push_back('{2'h3, sp});
  endtask : note_all

  always @(negedge ref_clk)
  begin
    while (notes.size() > 0)
    begin
      cur = notes.pop_front();
      samples_checked++;
      if (seen(cur.k) !== cur.v)
      begin
        mismatches++;
        $display("[FAIL] %0t kind %0d got %h exp %h", $time, cur.k,
                 seen(cur.k), cur.v);
      end
    end
  end

  // ------------------------------
  // Drivers
  // ------------------------------
  // Idle cycle between steps keeps each pulse a single cycle wide
  task automatic go();
    @(posedge ref_clk);
    {ptr_load, load_status_instr, set_control_bit_instr, trap_taken,
     clear_control_bit_instr, load_page_instr, set_product_mode_instr,
     alu_overflow, overflow_branch, test_update, leading_sign_instr_test} <= '0;
    carry_op <= cy_none;
    clk_en <= 1'h1;
    @(posedge ref_clk);
    note_all();
    // Level inputs feed live outputs, so hold them past the compare
    @(posedge ref_clk);
  endtask : go

  task automatic reset_dut();
    @(posedge ref_clk);
    rst_n <= 1'h0;
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'h1;
    {e_ptr, e_buf, e_page, e_shift, e_ovf, e_sat, e_ram, e_test} = '0;
    {e_mask, e_sign, e_cy, e_xo} = 4'hf;
    go();
    $display("Reset values checked");
  endtask : reset_dut

  task automatic apply(input int k);
    logic [31:0] r;
    logic [15:0] w;
    logic [2:0]  s;
    r = $urandom();
    instr_low_bits <= r[6:0];
    {maskable_irq_req, nonmask_irq_req, add_plain_instr} <= r[9:7];
    product_holding_reg <= $urandom();
    r = $urandom();
    w = {r[15:5], e_xo, r[3:0]};
    case (k)
      0:
      begin
        ptr_load <= 1'h1;
        ptr_src <= ptr_src_type'(r[4:3]);
        ptr_value <= r[2:0];
        if (r[4:3] != 2'h0)
          {e_buf, e_ptr} = {e_ptr, r[2:0]};
      end
      1:
      begin
        load_status_instr <= 1'h1;
        status_sel_one <= r[16];
        status_wdata <= w;
        e_ptr = w[15:13];
        if (r[16])
          {e_buf, e_ram, e_test, e_sign, e_cy, e_shift} = {w[15:9], w[1:0]};
        else
          {e_ovf, e_sat, e_page} = {w[12:11], w[8:0]};
      end
      2:
      begin
        s = r[2:0] % 3'h7;
        control_bit_sel <= bit_sel_type'(s);
        set_control_bit_instr <= r[3];
        clear_control_bit_instr <= ~r[3];
        case (s)
          3'h0: e_cy = r[3];
          3'h1: e_ram = r[3];
          3'h2: e_mask = r[3];
          3'h3: e_sat = r[3];
          3'h4: e_sign = r[3];
          3'h5: e_test = r[3];
          default: e_xo = r[3];
        endcase
      end
      3:
      begin
        s = 3'h1 + r[2:0] % 3'h5;
        carry_op <= carry_op_type'(s);
        alu_carry_out <= r[3];
        shift_carry_in <= r[4];
        case (s)
          3'h3: e_cy = e_cy | r[3];
          3'h4: e_cy = e_cy & r[3];
          3'h5: e_cy = r[4];
          default: e_cy = r[3];
        endcase
      end
      4:
      begin
        {alu_overflow, overflow_branch} <= r[1:0];
        e_ovf = r[1] | (e_ovf & ~r[0]);
      end
      5:
      begin
        trap_taken <= 1'h1;
        e_mask = 1'h1;
      end
      6:
      begin
        {test_update, leading_sign_instr_test} <= {r[0], ~r[0]};
        {tested_bit, aux_compare_true, acc_top_bits} <= r[4:1];
        e_test = r[0] ? r[4] | r[3] : r[2] ^ r[1];
      end
      7:
      begin
        load_page_instr <= 1'h1;
        page_value <= r[8:0];
        e_page = r[8:0];
      end
      8:
      begin
        set_product_mode_instr <= 1'h1;
        mode_value <= r[1:0];
        e_shift = r[1:0];
      end
      default: // Frozen cycle must ignore the page load
      begin
        clk_en <= 1'h0;
        load_page_instr <= 1'h1;
        page_value <= r[8:0];
      end
    endcase
    go();
  endtask : apply

  // ------------------------------
  // Sequence, watchdog, verdict
  // ------------------------------
  task automatic close_out();
    $display("Checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : close_out

  initial
  begin
    ref_clk = 1'h0;
    forever #5 ref_clk = ~ref_clk;
  end

  initial
  begin
    #100us;
    mismatches++;
    $display("Watchdog expired");
    close_out();
  end

  initial
  begin
    {rst_n, ptr_load, load_status_instr, status_sel_one, trap_taken,
     set_control_bit_instr, clear_control_bit_instr, load_page_instr,
     set_product_mode_instr, alu_carry_out, shift_carry_in, alu_overflow,
     overflow_branch, test_update, tested_bit, aux_compare_true, leading_sign_instr_test,
     maskable_irq_req, nonmask_irq_req, add_plain_instr} = '0;
    {ptr_value, status_wdata, page_value, mode_value, acc_top_bits,
     instr_low_bits, product_holding_reg} = '0;
    {mismatches, samples_checked} = '0;
    clk_en = 1'h1;
    ptr_src = ptr_none;
    control_bit_sel = sel_carry;
    carry_op = cy_none;
    void'($urandom(32'h7d00));
    // Second pass resets in mid-run with fields away from reset values
    repeat (2)
    begin
      reset_dut();
      repeat (300) apply($urandom_range(9));
      $display("Random instruction pass done");
    end
    close_out();
  end
endmodule : testbench
